// ### inc/phy_regs_pkg.sv
// Constants and types for the management register bank and its serial port.
package phy_regs_pkg;
   // ==========================================================
   // Register space
   localparam int REG_COUNT = 32;
   localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_VENDOR_FIRST = 5'h10;
   localparam logic [4:0] ADDR_AUTO_MDIX = 5'h1C;
   localparam logic [15:0] GENERIC_RESET = 16'h0000;

   // ==========================================================
   // Basic control field positions
   localparam int BC_RESET = 15;
   localparam int BC_LOOPBACK = 14;
   localparam int BC_SPEED_LSB = 13;
   localparam int BC_AN_ENABLE = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_ISOLATE = 10;
   localparam int BC_AN_RESTART = 9;
   localparam int BC_DUPLEX = 8;
   localparam int BC_RSVD7 = 7;
   localparam int BC_SPEED_MSB = 6;

   // ==========================================================
   // Basic control reset values
   localparam logic BC_LOOPBACK_RST = 1'b0;
   localparam logic BC_AN_ENABLE_RST = 1'b1;
   localparam logic BC_POWER_DOWN_RST = 1'b0;
   localparam logic BC_ISOLATE_RST = 1'b0;
   localparam logic BC_DUPLEX_RST = 1'b1;
   localparam logic BC_RSVD7_RST = 1'b0;

   // ==========================================================
   // Crossover control fields in the vendor register
   localparam int MDIX_MANUAL_BIT = 7;
   localparam int MDIX_SELECT_BIT = 6;

   // Speed encoding as {MSB, LSB} of the speed select pair.
   typedef enum logic [1:0] {
      SPEED_10 = 2'h0,
      SPEED_100 = 2'h1,
      SPEED_1000 = 2'h2,
      SPEED_RSVD = 2'h3
   } speed_t;

   // ==========================================================
   // Timing
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int GRST_WAIT_US = 1000;
   localparam int GRST_WAIT_CYCLES = GRST_WAIT_US * (CLK_FREQ_HZ / 1_000_000);

   // ==========================================================
   // Serial management frame
   localparam int PREAMBLE_BITS = 32;
   localparam int HDR_BITS = 13;
   localparam int DATA_BITS = 16;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   typedef enum logic [3:0] {
      FR_PRE = 4'h1,
      FR_HDR = 4'h2,
      FR_TA = 4'h4,
      FR_DATA = 4'h8
   } frame_state_t;
endpackage : phy_regs_pkg

// ### inc/mgmt_if.sv
// Carrier between the serial frame engine and the register bank.
`timescale 1ns/1ps
`default_nettype none
interface mgmt_if;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [15:0] rdata;
   logic busy;

   modport frame (output addr, output wdata, output wr_stb, output rd_stb,
                  input rdata, input busy);
   modport bank (input addr, input wdata, input wr_stb, input rd_stb,
                 output rdata, output busy);
endinterface : mgmt_if
`default_nettype wire

// ### rtl/mdio_frame.sv
// Serial management frame engine: decodes frames and drives read data.
`timescale 1ns/1ps
`default_nettype none
module mdio_frame (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   mgmt_if.frame mgmt
);
   import phy_regs_pkg::*;

   frame_state_t state;
   logic mdc_q;
   logic mdc_rise;
   logic [5:0] ones;
   logic [4:0] cnt;
   logic [11:0] hdr;
   logic [12:0] full_hdr;
   logic is_read;
   logic [15:0] shreg;

   // Management clock edges are found by sampling it on the core clock.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mdc_q <= 1'b0;
      end else begin
         mdc_q <= mdc;
      end
   end
   assign mdc_rise = mdc & ~mdc_q;
   assign full_hdr = {hdr, mdio_in};

   // Frame sequencing; output changes just after the clock rises.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= FR_PRE;
         ones <= 6'h00;
         cnt <= 5'h00;
         hdr <= 12'h000;
         is_read <= 1'b0;
         shreg <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
         mgmt.addr <= 5'h00;
         mgmt.wdata <= 16'h0000;
         mgmt.wr_stb <= 1'b0;
         mgmt.rd_stb <= 1'b0;
      end else begin
         mgmt.wr_stb <= 1'b0;
         mgmt.rd_stb <= 1'b0;
         if (mdc_rise) begin
            case (state)
               FR_PRE: begin
                  if (mdio_in) begin
                     if (ones != 6'(PREAMBLE_BITS)) begin
                        ones <= ones + 6'h01;
                     end
                  end else if (ones == 6'(PREAMBLE_BITS)) begin
                     state <= FR_HDR;
                     cnt <= 5'h00;
                  end else begin
                     ones <= 6'h00;
                  end
               end
               FR_HDR: begin
                  hdr <= full_hdr[11:0];
                  cnt <= cnt + 5'h01;
                  if (cnt == 5'(HDR_BITS - 1)) begin
                     ones <= 6'h00;
                     cnt <= 5'h00;
                     mgmt.addr <= full_hdr[4:0];
                     is_read <= (full_hdr[11:10] == OP_READ);
                     // Foreign address, bad start or a bank still in its
                     // post-power-down reset: the frame is let pass.
                     if (full_hdr[12] && full_hdr[9:5] == phy_addr &&
                         !mgmt.busy && (full_hdr[11:10] == OP_READ ||
                         full_hdr[11:10] == OP_WRITE)) begin
                        state <= FR_TA;
                        mgmt.rd_stb <= (full_hdr[11:10] == OP_READ); // R1
                     end else begin
                        state <= FR_PRE;
                     end
                  end
               end
               FR_TA: begin
                  cnt <= cnt + 5'h01;
                  if (cnt == 5'h00) begin
                     if (is_read) begin
                        mdio_oe <= 1'b1;
                        mdio_out <= 1'b0;
                        shreg <= mgmt.rdata;
                     end
                  end else begin
                     state <= FR_DATA;
                     cnt <= 5'h00;
                     mdio_out <= is_read & shreg[15];
                     shreg <= {shreg[14:0], 1'b0};
                  end
               end
               default: begin
                  cnt <= cnt + 5'h01;
                  shreg <= {shreg[14:0], mdio_in};
                  mdio_out <= is_read & shreg[15];
                  if (cnt == 5'(DATA_BITS - 1)) begin
                     state <= FR_PRE;
                     mdio_oe <= 1'b0;
                     mdio_out <= 1'b0;
                     if (!is_read) begin
                        mgmt.wdata <= {shreg[14:0], mdio_in};
                        mgmt.wr_stb <= 1'b1; // R1
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule : mdio_frame
`default_nettype wire

// ### rtl/phy_std_regs.sv
// Directly addressed management register bank with basic control logic.
// Functional notes
// R1 - Thirty-two registers, each read and written directly by address.
// R2 - Addresses 0h-Fh hold standard layouts, 10h-1Fh vendor functions.
// R3 - Writing one to bit 15 resets the transceiver; reads zero.
// R4 - Bits 6 and 13 pick speed 1000/100/10; ignored under negotiation.
// R5 - Bit 12 enables negotiation, default one; result overrides speed, duplex.
// R6 - Negotiation off disables auto crossover; register 1Ch then sets it.
// R7 - Bit 14 selects loopback mode, default zero.
// R8 - Bit 11 powers down; clearing it resets all, wait 1 ms.
// R9 - Bit 10 isolates the transceiver from its MAC interface.
// R10 - Writing one to bit 9 restarts negotiation, then it clears.
`timescale 1ns/1ps
`default_nettype none
module phy_std_regs #(
   parameter int GRST_CYCLES = phy_regs_pkg::GRST_WAIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   input wire phy_regs_pkg::speed_t strap_speed,
   input wire phy_regs_pkg::speed_t an_speed,
   input wire logic an_full_duplex,
   output logic soft_reset_pulse,
   output logic an_restart_pulse,
   output logic loopback_en,
   output logic isolate_en,
   output logic power_down,
   output logic an_enable,
   output phy_regs_pkg::speed_t eff_speed,
   output logic eff_full_duplex,
   output logic auto_mdix_en,
   output logic manual_mdix,
   output logic mgmt_busy
);
   import phy_regs_pkg::*;

   mgmt_if mgmt ();

   logic spd_msb;
   logic spd_lsb;
   logic duplex;
   logic rsvd7;
   logic strap_done;
   logic grst_active;
   logic [31:0] grst_cnt;
   logic [15:0] regs [1:REG_COUNT-1];
   logic [15:0] reg0_view;
   logic wr0;
   logic restore;

   // Picks the link speed from the manual pair, or the negotiated result.
   function automatic speed_t pick_speed(input logic an_on,
                                         input speed_t manual,
                                         input speed_t negotiated);
      speed_t res;
      res = an_on ? negotiated : manual;
      // The reserved code would leave the line undefined, so run slowest.
      if (res == SPEED_RSVD) begin
         res = SPEED_10;
      end
      return res;
   endfunction : pick_speed

   // ==========================================================
   // Serial port
   mdio_frame u_frame (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe),
      .phy_addr(phy_addr),
      .mgmt(mgmt.frame)
   );

   assign wr0 = mgmt.wr_stb && mgmt.addr == ADDR_BASIC_CONTROL;
   // A software reset and the end of the power-down reset both restore
   // every register to its default.
   assign restore = (wr0 && mgmt.wdata[BC_RESET]) ||
                    (grst_active && grst_cnt == 32'h00000001);

   // ==========================================================
   // Basic control register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         loopback_en <= BC_LOOPBACK_RST;
         an_enable <= BC_AN_ENABLE_RST;
         power_down <= BC_POWER_DOWN_RST;
         isolate_en <= BC_ISOLATE_RST;
         duplex <= BC_DUPLEX_RST;
         rsvd7 <= BC_RSVD7_RST;
      end else if (restore) begin
         loopback_en <= BC_LOOPBACK_RST; // R3
         an_enable <= BC_AN_ENABLE_RST;
         power_down <= BC_POWER_DOWN_RST;
         isolate_en <= BC_ISOLATE_RST;
         duplex <= BC_DUPLEX_RST;
         rsvd7 <= BC_RSVD7_RST;
      end else if (wr0) begin
         loopback_en <= mgmt.wdata[BC_LOOPBACK]; // R7
         an_enable <= mgmt.wdata[BC_AN_ENABLE]; // R5
         power_down <= mgmt.wdata[BC_POWER_DOWN]; // R8
         isolate_en <= mgmt.wdata[BC_ISOLATE]; // R9
         duplex <= mgmt.wdata[BC_DUPLEX];
         rsvd7 <= mgmt.wdata[BC_RSVD7];
      end
   end

   // Speed bits default from the strap, which is caught after reset release.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         spd_msb <= 1'b0;
         spd_lsb <= 1'b0;
         strap_done <= 1'b0;
      end else if (!strap_done || restore) begin
         spd_msb <= strap_speed[1];
         spd_lsb <= strap_speed[0];
         strap_done <= 1'b1;
      end else if (wr0) begin
         spd_msb <= mgmt.wdata[BC_SPEED_MSB]; // R4
         spd_lsb <= mgmt.wdata[BC_SPEED_LSB]; // R4
      end
   end

   // Self-clearing command bits surface as one-cycle pulses and never store.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         soft_reset_pulse <= 1'b0;
         an_restart_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= wr0 && mgmt.wdata[BC_RESET]; // R3
         an_restart_pulse <= wr0 && mgmt.wdata[BC_AN_RESTART] &&
                             !mgmt.wdata[BC_RESET]; // R10
      end
   end

   // ==========================================================
   // Internal global reset after leaving power-down
   // The wait is counted in core clocks, so the count must be rescaled
   // if the core clock rate ever changes.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         grst_active <= 1'b0;
         grst_cnt <= 32'h00000000;
      end else if (grst_active) begin
         grst_cnt <= grst_cnt - 32'h00000001;
         if (grst_cnt == 32'h00000001) begin
            grst_active <= 1'b0;
         end
      end else if (wr0 && power_down && !mgmt.wdata[BC_POWER_DOWN] &&
                   !mgmt.wdata[BC_RESET]) begin
         grst_active <= 1'b1; // R8
         grst_cnt <= 32'(GRST_CYCLES);
      end
   end
   // Frames arriving during the wait are dropped, protecting the reset.
   assign mgmt.busy = grst_active; // R8
   assign mgmt_busy = grst_active;

   // ==========================================================
   // Remaining standard and vendor registers, plain storage
   // Status, identity and counter contents are not modelled: every
   // address above zero keeps what was last written, so software that
   // expects read-only content there will see its own data instead.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 1; i < REG_COUNT; i++) begin
            regs[i] <= GENERIC_RESET;
         end
      end else if (restore) begin
         for (int i = 1; i < REG_COUNT; i++) begin
            regs[i] <= GENERIC_RESET;
         end
      end else if (mgmt.wr_stb && mgmt.addr != ADDR_BASIC_CONTROL) begin
         regs[mgmt.addr] <= mgmt.wdata; // R1 R2
      end
   end

   // Basic control as read back; the reset bit always shows zero.
   assign reg0_view = {1'b0, loopback_en, spd_lsb, an_enable, power_down,
                       isolate_en, 1'b0, duplex, rsvd7, spd_msb,
                       6'h00}; // R3

   // Read data is captured on the read strobe and held for the shifter.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mgmt.rdata <= 16'h0000;
      end else if (mgmt.rd_stb) begin
         if (mgmt.addr == ADDR_BASIC_CONTROL) begin
            mgmt.rdata <= reg0_view; // R1
         end else begin
            mgmt.rdata <= regs[mgmt.addr]; // R1 R2
         end
      end
   end

   // ==========================================================
   // Effective link settings
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         eff_speed <= SPEED_10;
         eff_full_duplex <= 1'b0;
         auto_mdix_en <= 1'b0;
         manual_mdix <= 1'b0;
      end else begin
         eff_speed <= pick_speed(an_enable, speed_t'({spd_msb, spd_lsb}),
                                 an_speed); // R4 R5
         eff_full_duplex <= an_enable ? an_full_duplex : duplex; // R5
         // Auto crossover needs negotiation; without it the vendor
         // register decides the pair assignment.
         auto_mdix_en <= an_enable &&
                         !regs[ADDR_AUTO_MDIX][MDIX_MANUAL_BIT]; // R6
         manual_mdix <= regs[ADDR_AUTO_MDIX][MDIX_SELECT_BIT]; // R6
      end
   end
endmodule : phy_std_regs
`default_nettype wire

// ### testbench/phy_std_regs_props.sv
// Concurrent checks on the ports of the management register bank.
`timescale 1ns/1ps
`default_nettype none
module phy_std_regs_props #(
   parameter int GRST_CYCLES = 50
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire phy_regs_pkg::speed_t an_speed,
   input wire logic an_full_duplex,
   input wire logic soft_reset_pulse,
   input wire logic an_restart_pulse,
   input wire logic loopback_en,
   input wire logic an_enable,
   input wire phy_regs_pkg::speed_t eff_speed,
   input wire logic eff_full_duplex,
   input wire logic auto_mdix_en,
   input wire logic mgmt_busy
);
   import phy_regs_pkg::*;
   logic [1:0] up;
   logic [31:0] busy_len;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // ======================================================
   // Helpers
   // Effective outputs are only meaningful from the third edge on.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end

   // Length of the current wait after leaving power-down.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) busy_len <= 32'h0;
      else if (mgmt_busy) busy_len <= busy_len + 32'h1;
      else busy_len <= 32'h0;
   end

   // ======================================================
   // Assertions
   AST_SRST_RESTORE: assert property (soft_reset_pulse |->
      an_enable && !loopback_en ##1 !soft_reset_pulse)
      else $error("soft reset bad");
   AST_ANR_ONE: assert property (an_restart_pulse |->
      !soft_reset_pulse ##1 !an_restart_pulse) else $error("restart bad");
   AST_SPEED_AN: assert property (up == 2'h3 && an_enable &&
      $past(an_enable) |-> eff_speed == $past(an_speed))
      else $error("speed not negotiated");
   AST_SPEED_RSVD: assert property (eff_speed != SPEED_RSVD)
      else $error("reserved speed used");
   AST_DUPLEX_AN: assert property (up == 2'h3 && an_enable &&
      $past(an_enable) |-> eff_full_duplex == $past(an_full_duplex))
      else $error("duplex not negotiated");
   AST_MDIX_OFF: assert property (up == 2'h3 && !an_enable &&
      !$past(an_enable) |-> !auto_mdix_en) else $error("crossover on");
   AST_BUSY_LEN: assert property ($fell(mgmt_busy) |->
      busy_len >= GRST_CYCLES - 1 && busy_len <= GRST_CYCLES + 2)
      else $error("wait length wrong");
   AST_BUSY_QUIET: assert property (mgmt_busy |-> !$rose(mdio_oe))
      else $error("answered during wait");
   AST_OE_TA: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround not zero");
   cover property (soft_reset_pulse);
   cover property (an_restart_pulse);
   cover property ($fell(mgmt_busy));
   cover property ($rose(mdio_oe));
endmodule : phy_std_regs_props

bind phy_std_regs phy_std_regs_props #(.GRST_CYCLES(GRST_CYCLES)) i_props (
   .ref_clk(ref_clk), .resetn(resetn), .mdio_out(mdio_out),
   .mdio_oe(mdio_oe), .an_speed(an_speed), .an_full_duplex(an_full_duplex),
   .soft_reset_pulse(soft_reset_pulse), .an_restart_pulse(an_restart_pulse),
   .loopback_en(loopback_en),
   .an_enable(an_enable), .eff_speed(eff_speed),
   .eff_full_duplex(eff_full_duplex), .auto_mdix_en(auto_mdix_en),
   .mgmt_busy(mgmt_busy));
`default_nettype wire

// ### testbench/mdio_mgr.sv
// Station management controller model that sends serial frames.
`timescale 1ns/1ps
`default_nettype none
module mdio_mgr (
   input wire logic ref_clk,
   input wire logic mdio_wire,
   output logic mdc,
   output logic m_out,
   output logic m_oe,
   output logic [15:0] rd_data,
   output logic rd_valid
);
   // ======================================================
   // Idle state
   // Clock stands low between frames; the line is left to the pull-up.
   initial begin
      mdc = 1'b0;
      m_out = 1'b0;
      m_oe = 1'b0;
      rd_data = 16'h0000;
      rd_valid = 1'b0;
   end

   // One frame, mdc period of 8 cycles; data moves only while mdc is low.
   task automatic frame(input logic rd, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd);
      logic [63:0] bits;
      bits = {32'hFFFFFFFF, 2'b01, rd, !rd, pa, ra, 2'b10, wd};
      for (int i = 63; i >= 0; i--) begin
         @(negedge ref_clk);
         mdc = 1'b0;
         m_oe = !(rd && i < 18);
         m_out = bits[i];
         repeat (4) @(negedge ref_clk);
         if (i < 16) rd_data[i] = mdio_wire;
         mdc = 1'b1;
         repeat (3) @(negedge ref_clk);
      end
      @(negedge ref_clk);
      mdc = 1'b0;
      m_oe = 1'b0;
      repeat (4) @(negedge ref_clk);
      rd_valid = rd;
      @(negedge ref_clk);
      rd_valid = 1'b0;
   endtask : frame
endmodule : mdio_mgr
`default_nettype wire

// ### testbench/phy_std_regs_basic_control_test.sv
// Self-checking bench for the management register bank.
`timescale 1ns/1ps
`default_nettype none
module phy_std_regs_basic_control_test;
   import phy_regs_pkg::*;
   localparam int GRST = 2000;
   logic ref_clk, resetn, mdc, mdio_in, mdio_out, mdio_oe;
   logic m_out, m_oe, rd_valid, an_full_duplex, eff_full_duplex;
   logic soft_reset_pulse, an_restart_pulse, loopback_en, isolate_en;
   logic power_down, an_enable, auto_mdix_en, manual_mdix, mgmt_busy;
   logic [4:0] phy_addr;
   speed_t strap_speed, an_speed, eff_speed;
   logic [15:0] rd_data, w;
   logic [31:0] seed = 32'h5FF653DD;
   int err_count = 0;
   int num_checks = 0;
   int n_srst = 0;
   int n_anr = 0;
   logic [15:0] exp_q[$];

   // The line has a pull-up, so nobody driving reads as one.
   assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);

   phy_std_regs #(.GRST_CYCLES(GRST)) i_dut (.ref_clk(ref_clk),
      .resetn(resetn), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .phy_addr(phy_addr), .strap_speed(strap_speed),
      .an_speed(an_speed), .an_full_duplex(an_full_duplex),
      .soft_reset_pulse(soft_reset_pulse),
      .an_restart_pulse(an_restart_pulse), .loopback_en(loopback_en),
      .isolate_en(isolate_en), .power_down(power_down),
      .an_enable(an_enable), .eff_speed(eff_speed),
      .eff_full_duplex(eff_full_duplex), .auto_mdix_en(auto_mdix_en),
      .manual_mdix(manual_mdix), .mgmt_busy(mgmt_busy));
   mdio_mgr i_mgr (.ref_clk(ref_clk), .mdio_wire(mdio_in), .mdc(mdc),
      .m_out(m_out), .m_oe(m_oe), .rd_data(rd_data), .rd_valid(rd_valid));

   // ======================================================
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      i_mgr.frame(1'b0, 5'h03, ra, d);
   endtask : wr

   // The expected word is noted before the frame goes out.
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      exp_q.push_back(e);
      i_mgr.frame(1'b1, 5'h03, ra, 16'h0000);
   endtask : rd

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // ======================================================
   // Monitors
   // Each finished read takes the oldest noted word.
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) chk(rd_data, exp_q.pop_front());
      if (soft_reset_pulse === 1'b1) n_srst++;
      if (an_restart_pulse === 1'b1) n_anr++;
   end

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // A full run is near 43000 cycles; more than twice that means a hang.
   initial begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      give_verdict();
   end

   // ======================================================
   // Main sequence
   initial begin
      resetn = 1'b0;
      phy_addr = 5'h03;
      strap_speed = SPEED_100;
      an_speed = SPEED_1000;
      an_full_duplex = 1'b1;
      repeat (6) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(16'({loopback_en, isolate_en, power_down, an_enable}), 16'h1);
      chk(16'({eff_speed, eff_full_duplex}), 16'h5);
      rd(ADDR_BASIC_CONTROL, 16'h3100);
      for (int i = 1; i < REG_COUNT; i++) begin
         seed = xorshift(seed);
         w = seed[15:0];
         wr(5'(i), w);
         rd(5'(i), w);
      end
      wr(ADDR_AUTO_MDIX, 16'h00C0);
      chk(16'({auto_mdix_en, manual_mdix}), 16'h1);
      // Manual speeds with negotiation off, the reserved pair included.
      for (int k = 0; k < 4; k++) begin
         w = 16'h4000 | (16'(k & 1) << BC_SPEED_LSB);
         w = w | (16'(k >> 1) << BC_SPEED_MSB);
         wr(ADDR_BASIC_CONTROL, w);
         chk(16'({loopback_en, an_enable, auto_mdix_en,
            eff_full_duplex}), 16'h8);
         chk(16'(eff_speed), (k == 3) ? 16'h0 : 16'(k));
      end
      seed = xorshift(seed);
      an_speed = speed_t'(seed[1] ? 2'h2 : {1'b0, seed[0]});
      an_full_duplex = seed[2];
      wr(ADDR_BASIC_CONTROL, 16'h1040);
      chk(16'({eff_speed, eff_full_duplex}), 16'({an_speed, seed[2]}));
      wr(ADDR_AUTO_MDIX, 16'h0040);
      chk(16'({auto_mdix_en, manual_mdix}), 16'h3);
      wr(ADDR_BASIC_CONTROL, 16'h1600);
      chk(16'({isolate_en, n_anr[1:0]}), 16'h5);
      rd(ADDR_BASIC_CONTROL, 16'h1400);
      wr(ADDR_BASIC_CONTROL, 16'hC000);
      chk(16'({loopback_en, an_enable, manual_mdix, n_srst[1:0]}), 16'h9);
      rd(ADDR_AUTO_MDIX, 16'h0000);
      rd(ADDR_BASIC_CONTROL, 16'h3100);
      wr(ADDR_BASIC_CONTROL, 16'h1900);
      chk(16'(power_down), 16'h1);
      wr(ADDR_BASIC_CONTROL, 16'h1100);
      chk(16'({power_down, mgmt_busy}), 16'h1);
      rd(ADDR_BASIC_CONTROL, 16'hFFFF);
      // The controller holds off until the wait is over.
      for (int t = 0; t < 3000 && mgmt_busy !== 1'b0; t++) begin
         @(negedge ref_clk);
      end
      chk(16'(mgmt_busy), 16'h0);
      rd(ADDR_BASIC_CONTROL, 16'h3100);
      phy_addr = 5'h04;
      rd(ADDR_BASIC_CONTROL, 16'hFFFF);
      give_verdict();
   end
endmodule : phy_std_regs_basic_control_test
`default_nettype wire
